/* design/rptl_device.sv */
// Device end: reset-pin entry decoder and programming-mode lock
// Summary of operation
// - Symbols split in sixteen sub-periods, four states
// - Pin high over 2 ms exits test
// - Host sends break, syncs, two keys, terminator
// - Host returns pin low after terminator
// - Mismatch abandons sequence; fresh break needed
// - Break needs low beyond 2^16 oscillator periods
// - Third sync measures bit time, 16-bit buffer
// - Key bytes must equal 5A then 96
// - Terminator high checked; falling edge sets hold
// - Data or terminator symbol over 18 sub-periods aborts decoding
// - Sync over 2^15 oscillator periods aborts
// - Programming mode locked after power-on
// - Locked: only erases and read-verify run
// - Matching verify of key range unlocks
// - Erased key of all FF unlocks
// - Each key trial takes about 10 us
// - Serial port: busy, out, in, clock, enable
// - Eight programming commands supported
`timescale 1ns/1ps
module rptl_device #(
	parameter int unsigned BREAK_CYC = (1 << rptl_pkg::BREAK_OSC_LOG2) * 6,
	parameter int unsigned SYNC_CYC  = (1 << rptl_pkg::SYNC_OSC_LOG2) * 6,
	parameter int unsigned EXIT_CYC  = rptl_pkg::HIGH_EXIT_CYC,
	parameter int unsigned MEM_DEPTH = 65536
) (
	input  wire logic  clk_i,
	input  wire logic  srst_i,
	rptl_if.device     link,
	input  wire logic [7:0] key_byte_i [rptl_pkg::KEY_BYTES],
	output logic       test_mode_o,
	output logic       program_mode_o,
	output logic       unlocked_o,
	output logic [15:0] measured_bit_time_o,
	output logic       cmd_valid_o,
	output logic [7:0] cmd_op_o,
	output logic [15:0] cmd_addr_o,
	output logic [7:0] cmd_data_o
);
	typedef enum logic [2:0] {
		RPTL_ST_IDLE  = 3'b000,
		RPTL_ST_BREAK = 3'b001,
		RPTL_ST_SYNC  = 3'b010,
		RPTL_ST_BYTE1 = 3'b011,
		RPTL_ST_BYTE2 = 3'b100,
		RPTL_ST_TERM  = 3'b101,
		RPTL_ST_HOLD  = 3'b110
	} rptl_st_t;
	rptl_st_t state;
	rptl_st_t next_state;

	// Two-flop synchronisers for every pin input
	logic [1:0] rst_s, clk_s, enb_s, din_s;
	always_ff @(posedge clk_i) begin
		rst_s <= {rst_s[0], link.reset_pin_n};
		clk_s <= {clk_s[0], link.prog_clock_in};
		enb_s <= {enb_s[0], link.prog_enable_n};
		din_s <= {din_s[0], link.prog_data_in};
	end
	wire pin = rst_s[1];

	logic        sym_valid, sym_bad, pin_fall;
	rptl_pkg::rptl_sym_t sym;
	logic [31:0] lo_cnt, hi_cnt, sync_cnt;
	logic [1:0]  sync_n;
	logic [2:0]  bit_n;
	logic [7:0]  shreg;
	logic        clr_dec;

	rptl_sym_decoder u_dec (
		.clk_i       (clk_i),
		.srst_i      (srst_i),
		.clr_i       (clr_dec),
		.pin_i       (pin),
		.bit_time_i  (measured_bit_time_o),
		.sym_valid_o (sym_valid),
		.sym_o       (sym),
		.sym_bad_o   (sym_bad),
		.fall_o      (pin_fall)
	);

	wire break_seen = (lo_cnt > BREAK_CYC);
	wire high_exit  = (hi_cnt > EXIT_CYC);
	wire sync_tmo   = (state == RPTL_ST_SYNC) && (sync_cnt > SYNC_CYC);
	wire in_frame   = (state != RPTL_ST_IDLE) && (state != RPTL_ST_BREAK) && (state != RPTL_ST_HOLD);
	// Syncs come before the bit time is known, so only their period is policed
	wire abort      = in_frame && ((sym_bad && state != RPTL_ST_SYNC) || sync_tmo);
	wire [7:0] byte_now = {shreg[6:0], (sym == rptl_pkg::RPTL_SYM_ONE)};
	wire in_bytes   = (state == RPTL_ST_BYTE1) || (state == RPTL_ST_BYTE2);
	wire data_sym   = sym_valid && !sym_bad && in_bytes &&
		(sym == rptl_pkg::RPTL_SYM_ZERO || sym == rptl_pkg::RPTL_SYM_ONE);

	always_comb begin
		next_state = state;
		if (high_exit && state != RPTL_ST_BREAK)
			next_state = RPTL_ST_IDLE;
		else if (abort)
			next_state = RPTL_ST_IDLE;
		else begin
			case (state)
				RPTL_ST_IDLE:  if (break_seen) next_state = RPTL_ST_BREAK;
				RPTL_ST_BREAK: if (pin) next_state = RPTL_ST_SYNC;
				RPTL_ST_SYNC:
					if (sym_valid && sync_n == 2'd2) next_state = RPTL_ST_BYTE1;
				RPTL_ST_BYTE1:
					if (sym_valid && !data_sym) next_state = RPTL_ST_IDLE;
					else if (data_sym && bit_n == 3'd7)
						next_state = (byte_now == rptl_pkg::KEY_BYTE1) ? RPTL_ST_BYTE2 : RPTL_ST_IDLE;
				RPTL_ST_BYTE2:
					if (sym_valid && !data_sym) next_state = RPTL_ST_IDLE;
					else if (data_sym && bit_n == 3'd7)
						next_state = (byte_now == rptl_pkg::KEY_BYTE2) ? RPTL_ST_TERM : RPTL_ST_IDLE;
				RPTL_ST_TERM:
					if (sym_valid) next_state = RPTL_ST_IDLE;
					else if (pin_fall && sync_cnt > 32'(measured_bit_time_o) / 4 &&
						sync_cnt < 32'(measured_bit_time_o) * 5 / 8) next_state = RPTL_ST_HOLD;
				RPTL_ST_HOLD: next_state = RPTL_ST_HOLD;
				default:      next_state = RPTL_ST_IDLE;
			endcase
		end
	end

	// Decoder runs during break so the edge that ends it is seen
	assign clr_dec = (state == RPTL_ST_IDLE);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state <= RPTL_ST_IDLE;
			lo_cnt <= 32'h0;
			hi_cnt <= 32'h0;
			sync_cnt <= 32'h0;
			sync_n <= 2'd0;
			bit_n <= 3'd0;
			shreg <= 8'h00;
			measured_bit_time_o <= rptl_pkg::BIT_TIME_RST;
			test_mode_o <= 1'b0;
		end else begin
			state <= next_state;
			lo_cnt <= pin ? 32'h0 : (break_seen ? lo_cnt : lo_cnt + 32'h1);
			hi_cnt <= !pin ? 32'h0 : (high_exit ? hi_cnt : hi_cnt + 32'h1);
			sync_cnt <= (pin_fall && state == RPTL_ST_TERM) ? sync_cnt :
				(sym_valid || state == RPTL_ST_BREAK) ? 32'h0 : sync_cnt + 32'h1;
			if (state == RPTL_ST_SYNC && sym_valid) begin
				sync_n <= sync_n + 2'd1;
				if (sync_n == 2'd2)
					measured_bit_time_o <= sync_cnt[15:0] + 16'h1;
			end else if (clr_dec)
				sync_n <= 2'd0;
			if (data_sym) begin
				shreg <= byte_now;
				bit_n <= bit_n + 3'd1;
			end else if (clr_dec)
				bit_n <= 3'd0;
			test_mode_o <= (next_state == RPTL_ST_HOLD);
		end
	end

	// Programming serial port
	logic [31:0] rx;
	logic [5:0]  rx_n;
	logic [7:0]  tx;
	logic        sclk_q, erased;
	logic [7:0]  mem [MEM_DEPTH];
	logic [7:0]  info [256];
	logic [3:0]  kidx;
	logic        kmatch;
	logic [15:0] busy_cnt;
	logic        frame_done;
	wire sclk_rise = clk_s[1] & ~sclk_q;
	wire sclk_fall = ~clk_s[1] & sclk_q;
	wire [7:0] op = rx[31:24];
	wire allowed = unlocked_o || op == rptl_pkg::OP_ERASE_MAIN || op == rptl_pkg::OP_ERASE_MAIN_INFO ||
		op == rptl_pkg::OP_READ_VERIFY;
	wire [7:0] key_exp = erased ? rptl_pkg::ERASED_BYTE : key_byte_i[kidx[2:0]];

	always_ff @(posedge clk_i) begin
		sclk_q <= clk_s[1];
		cmd_valid_o <= 1'b0;
		frame_done <= 1'b0;
		if (srst_i) begin
			program_mode_o <= 1'b0;
			unlocked_o <= 1'b0;
			rx <= 32'h0;
			rx_n <= 6'd0;
			tx <= 8'h00;
			kidx <= 4'd0;
			kmatch <= 1'b1;
			erased <= 1'b0;
			busy_cnt <= 16'h0;
			cmd_op_o <= 8'h00;
			cmd_addr_o <= 16'h0000;
			cmd_data_o <= 8'h00;
			link.prog_busy <= 1'b0;
			link.prog_data_out <= 1'b0;
		end else begin
			program_mode_o <= test_mode_o;
			if (!test_mode_o)
				unlocked_o <= 1'b0;
			if (enb_s[1] || !test_mode_o)
				rx_n <= 6'd0;
			else if (sclk_rise && busy_cnt == 16'h0) begin
				rx <= {rx[30:0], din_s[1]};
				rx_n <= rx_n + 6'd1;
				if (rx_n == 6'(rptl_pkg::FRAME_BITS - 1))
					frame_done <= 1'b1;
			end
			if (sclk_fall && !enb_s[1]) begin
				link.prog_data_out <= tx[7];
				tx <= {tx[6:0], 1'b0};
			end
			if (frame_done) begin
				tx <= allowed ? rptl_pkg::RESP_OK : rptl_pkg::RESP_REFUSED;
				if (allowed) begin
					cmd_valid_o <= 1'b1;
					cmd_op_o <= op;
					cmd_addr_o <= rx[23:8];
					cmd_data_o <= rx[7:0];
				end
				case (op)
					rptl_pkg::OP_ERASE_MAIN, rptl_pkg::OP_ERASE_MAIN_INFO:
						erased <= 1'b1;
					rptl_pkg::OP_WRITE_MAIN, rptl_pkg::OP_FAST_WRITE:
						if (allowed) mem[rx[23:8]] <= rx[7:0];
					rptl_pkg::OP_WRITE_INFO:
						if (allowed) info[rx[15:8]] <= rx[7:0];
					rptl_pkg::OP_READ_INFO:
						if (allowed) tx <= info[rx[15:8]];
					rptl_pkg::OP_READ_VERIFY: begin
						// One byte per frame; eighth byte at key top decides
						busy_cnt <= 16'(rptl_pkg::KEY_TRIAL_CYC);
						if (rx[23:8] == rptl_pkg::KEY_ADDR_LO + 16'(kidx)) begin
							if (kidx == 4'd7) begin
								if (kmatch && rx[7:0] == key_exp) unlocked_o <= 1'b1;
								kidx <= 4'd0;
								kmatch <= 1'b1;
							end else begin
								kmatch <= kmatch && (rx[7:0] == key_exp);
								kidx <= kidx + 4'd1;
							end
						end else begin
							kidx <= 4'd0;
							kmatch <= 1'b1;
						end
					end
					default: ;
				endcase
			end else if (busy_cnt != 16'h0)
				busy_cnt <= busy_cnt - 16'h1;
			link.prog_busy <= (busy_cnt > 16'h1) || frame_done;
		end
	end
endmodule : rptl_device

/* design/rptl_pkg.sv */
// Package: shared constants for reset-pin test entry and program lock
package rptl_pkg;
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned SUB_PER_SYMBOL  = 16;
	localparam int unsigned BITTIME_MAX_SUB = 18;
	localparam int unsigned HIGH_EXIT_US    = 2000;
	localparam int unsigned HIGH_EXIT_CYC   = HIGH_EXIT_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned BREAK_OSC_LOG2  = 16;
	localparam int unsigned SYNC_OSC_LOG2   = 15;
	localparam int unsigned BREAK_HOST_US   = 4000;
	localparam int unsigned BREAK_HOST_CYC  = (BREAK_HOST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] BIT_TIME_RST    = 16'h3200;
	localparam logic [7:0]  KEY_BYTE1       = 8'h5a;
	localparam logic [7:0]  KEY_BYTE2       = 8'h96;
	localparam logic [7:0]  ERASED_BYTE     = 8'hff;
	localparam logic [15:0] KEY_ADDR_LO     = 16'heff8;
	localparam int unsigned KEY_BYTES       = 8;
	localparam int unsigned KEY_TRIAL_NS    = 10_000;
	localparam int unsigned KEY_TRIAL_CYC   = KEY_TRIAL_NS / CLK_PERIOD_NS;
	localparam logic [3:0]  ZERO_HI_MIN     = 4'h2;
	localparam logic [3:0]  ZERO_HI_MAX     = 4'h5;
	localparam logic [3:0]  ONE_HI_MIN      = 4'ha;
	localparam logic [3:0]  ONE_HI_MAX      = 4'hd;
	localparam logic [3:0]  TERM_HI_MIN     = 4'h6;
	localparam logic [3:0]  TERM_HI_MAX     = 4'h9;
	localparam logic [3:0]  SYNC_HI_MIN     = 4'he;
	typedef enum logic [1:0] {
		RPTL_SYM_ZERO = 2'b00,
		RPTL_SYM_ONE  = 2'b01,
		RPTL_SYM_SYNC = 2'b10,
		RPTL_SYM_TERM = 2'b11
	} rptl_sym_t;
	localparam logic [7:0] OP_ERASE_MAIN      = 8'h01;
	localparam logic [7:0] OP_ERASE_MAIN_INFO = 8'h02;
	localparam logic [7:0] OP_READ_VERIFY     = 8'h03;
	localparam logic [7:0] OP_WRITE_MAIN      = 8'h04;
	localparam logic [7:0] OP_READ_INFO       = 8'h05;
	localparam logic [7:0] OP_WRITE_INFO      = 8'h06;
	localparam logic [7:0] OP_FAST_WRITE      = 8'h07;
	localparam logic [7:0] OP_FAST_READ       = 8'h08;
	localparam logic [7:0] RESP_OK            = 8'ha5;
	localparam logic [7:0] RESP_REFUSED       = 8'he1;
	localparam int unsigned FRAME_BITS        = 32;
endpackage : rptl_pkg

/* design/rptl_if.sv */
// Interface: reset pin and programming serial port between programmer and device
`timescale 1ns/1ps
interface rptl_if;
	logic reset_pin_n;
	logic prog_clock_in;
	logic prog_enable_n;
	logic prog_data_in;
	logic prog_data_out;
	logic prog_busy;
	modport device (
		input  reset_pin_n,
		input  prog_clock_in,
		input  prog_enable_n,
		input  prog_data_in,
		output prog_data_out,
		output prog_busy
	);
	modport programmer (
		output reset_pin_n,
		output prog_clock_in,
		output prog_enable_n,
		output prog_data_in,
		input  prog_data_out,
		input  prog_busy
	);
endinterface : rptl_if

/* design/rptl_sym_decoder.sv */
// Duty-cycle symbol decoder for the reset pin
`timescale 1ns/1ps
module rptl_sym_decoder (
	input  wire logic                clk_i,
	input  wire logic                srst_i,
	input  wire logic                clr_i,
	input  wire logic                pin_i,
	input  wire logic [15:0]         bit_time_i,
	output logic                     sym_valid_o,
	output rptl_pkg::rptl_sym_t      sym_o,
	output logic                     sym_bad_o,
	output logic                     fall_o
);
	logic        pin_q;
	logic [15:0] sub_cnt;
	logic [4:0]  sub_idx;
	logic [4:0]  hi_subs;
	logic        seen_rise;
	wire         rise    = pin_i & ~pin_q;
	wire         fall    = ~pin_i & pin_q;
	wire  [15:0] sub_len = {4'h0, bit_time_i[15:4]};
	wire         sub_end = (sub_cnt + 16'h0001 >= sub_len);
	wire  [3:0]  hi4     = (hi_subs > 5'd15) ? 4'hf : hi_subs[3:0];

	assign fall_o = fall;

	always_ff @(posedge clk_i) begin
		pin_q <= pin_i;
		sym_valid_o <= 1'b0;
		sym_bad_o <= 1'b0;
		if (srst_i || clr_i) begin
			sub_cnt <= 16'h0000;
			sub_idx <= 5'd0;
			hi_subs <= 5'd0;
			seen_rise <= 1'b0;
			sym_o <= rptl_pkg::RPTL_SYM_ZERO;
		end else if (rise) begin
			// Symbol boundary is the rising edge; classify previous high time
			if (seen_rise) begin
				sym_valid_o <= 1'b1;
				if (hi4 >= rptl_pkg::SYNC_HI_MIN)
					sym_o <= rptl_pkg::RPTL_SYM_SYNC;
				else if (hi4 >= rptl_pkg::ONE_HI_MIN && hi4 <= rptl_pkg::ONE_HI_MAX)
					sym_o <= rptl_pkg::RPTL_SYM_ONE;
				else if (hi4 >= rptl_pkg::TERM_HI_MIN && hi4 <= rptl_pkg::TERM_HI_MAX)
					sym_o <= rptl_pkg::RPTL_SYM_TERM;
				else if (hi4 >= rptl_pkg::ZERO_HI_MIN && hi4 <= rptl_pkg::ZERO_HI_MAX)
					sym_o <= rptl_pkg::RPTL_SYM_ZERO;
				else
					sym_bad_o <= 1'b1;
			end
			seen_rise <= 1'b1;
			sub_cnt <= 16'h0000;
			sub_idx <= 5'd0;
			hi_subs <= 5'd0;
		end else if (seen_rise) begin
			if (sub_end) begin
				sub_cnt <= 16'h0000;
				if (sub_idx != 5'd31)
					sub_idx <= sub_idx + 5'd1;
				if (pin_i && hi_subs != 5'd31)
					hi_subs <= hi_subs + 5'd1;
			end else begin
				sub_cnt <= sub_cnt + 16'h0001;
			end
			if (sub_idx >= 5'(rptl_pkg::BITTIME_MAX_SUB))
				sym_bad_o <= 1'b1;
		end
	end
endmodule : rptl_sym_decoder

/* design/rptl_programmer.sv */
// Programmer end: drives entry waveform and serial command frames
`timescale 1ns/1ps
module rptl_programmer #(
	parameter int unsigned BREAK_CYC = rptl_pkg::BREAK_HOST_CYC,
	parameter int unsigned SYM_CYC   = 80000,
	parameter int unsigned SCLK_DIV  = 50
) (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	rptl_if.programmer       link,
	input  wire logic        enter_i,
	input  wire logic        cmd_valid_i,
	input  wire logic [31:0] cmd_frame_i,
	output logic             ready_o,
	output logic             resp_valid_o,
	output logic [7:0]       resp_o
);
	localparam int unsigned SUB = SYM_CYC / rptl_pkg::SUB_PER_SYMBOL;
	logic [31:0] cnt;
	logic [4:0]  sidx;
	logic [15:0] seq;
	logic [39:0] sh;
	logic [5:0]  n;
	logic [1:0]  busy_s, dout_s;
	logic        active, sending, sclk;
	logic [2:0]  ph;
	wire [3:0] hi_of = (sidx < 5'd3) ? 4'hf : (sidx < 5'd19) ? (seq[15] ? 4'hc : 4'h4) : 4'h8;
	always_ff @(posedge clk_i) begin
		busy_s <= {busy_s[0], link.prog_busy};
		dout_s <= {dout_s[0], link.prog_data_out};
		resp_valid_o <= 1'b0;
		if (srst_i) begin
			link.reset_pin_n <= 1'b1;
			link.prog_clock_in <= 1'b0;
			link.prog_enable_n <= 1'b1;
			link.prog_data_in <= 1'b0;
			cnt <= 32'h0; sidx <= 5'd0; seq <= 16'h0; ph <= 3'd0;
			sh <= 40'h0; n <= 6'd0; active <= 1'b0; sending <= 1'b0; sclk <= 1'b0;
			ready_o <= 1'b0; resp_o <= 8'h00;
		end else begin
			case (ph)
				3'd0: if (enter_i) begin
					ph <= 3'd1; cnt <= 32'h0; link.reset_pin_n <= 1'b0; ready_o <= 1'b0;
					seq <= {rptl_pkg::KEY_BYTE1, rptl_pkg::KEY_BYTE2};
				end
				3'd1: if (cnt >= BREAK_CYC) begin
					ph <= 3'd2; cnt <= 32'h0; sidx <= 5'd0;
				end else cnt <= cnt + 32'h1;
				3'd2: begin
					link.reset_pin_n <= (cnt < 32'(hi_of) * SUB);
					if (cnt >= SYM_CYC - 1) begin
						cnt <= 32'h0;
						if (sidx >= 5'd3 && sidx < 5'd19) seq <= {seq[14:0], 1'b0};
						if (sidx == 5'd19) begin
							ph <= 3'd3;
						end else sidx <= sidx + 5'd1;
					end else cnt <= cnt + 32'h1;
				end
				3'd3: begin
					// No closing edge: a short high pulse would read as a bad symbol
					link.reset_pin_n <= 1'b0; ph <= 3'd4; ready_o <= 1'b1;
				end
				3'd4: begin
					if (cmd_valid_i && ready_o) begin
						sh <= {cmd_frame_i, 8'h00}; n <= 6'd0; ready_o <= 1'b0;
						active <= 1'b1; link.prog_enable_n <= 1'b0; cnt <= 32'h0;
					end else if (active && !busy_s[1]) begin
						if (cnt >= SCLK_DIV - 1) begin
							cnt <= 32'h0; sclk <= ~sclk; link.prog_clock_in <= ~sclk;
							if (!sclk) begin
								if (n >= 6'd32) resp_o <= {resp_o[6:0], dout_s[1]};
							end else begin
								n <= n + 6'd1;
								sh <= {sh[38:0], 1'b0};
								if (n == 6'd39) begin
									active <= 1'b0; link.prog_enable_n <= 1'b1;
									ready_o <= 1'b1; resp_valid_o <= 1'b1;
								end
							end
						end else cnt <= cnt + 32'h1;
						link.prog_data_in <= sh[39];
					end
				end
				default: ph <= 3'd0;
			endcase
		end
	end
endmodule : rptl_programmer

/* dv/rptl_link_asserts.sv */
// Checker: wire-level timing of the reset pin and programming port
`timescale 1ns/1ps
module rptl_link_asserts #(
	parameter int unsigned BREAK_CYC = 2500,
	parameter int unsigned SYM_CYC   = 160
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic reset_pin_n,
	input wire logic prog_clock_in,
	input wire logic prog_enable_n,
	input wire logic prog_data_in,
	input wire logic prog_data_out,
	input wire logic prog_busy
);
	localparam int unsigned SUB  = SYM_CYC / 16;
	localparam int unsigned LONG = 2 * SYM_CYC;
	int unsigned hi_len;
	int unsigned lo_len;
	int unsigned hi_prev;
	int unsigned nclk;
	// High run starts large so the first low after reset counts as a break
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hi_len  <= 100000;
			lo_len  <= 0;
			hi_prev <= 100000;
			nclk    <= 0;
		end else begin
			hi_len  <= reset_pin_n ? hi_len + 1 : 0;
			lo_len  <= reset_pin_n ? 0 : lo_len + 1;
			hi_prev <= (!reset_pin_n && hi_len != 0) ? hi_len : hi_prev;
			nclk    <= prog_enable_n ? 0 : nclk + ($rose(prog_clock_in) ? 1 : 0);
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);
	sequence frame_end;
		$rose(prog_enable_n);
	endsequence
	sequence break_end;
		$rose(reset_pin_n) && hi_prev > LONG;
	endsequence
	sequence sym_end;
		$rose(reset_pin_n) && hi_prev < LONG && lo_len < LONG;
	endsequence
	reset_idle_a: assert property ($fell(srst_i) |-> reset_pin_n && prog_enable_n && !prog_busy)
		else $error("link not idle after reset");
	idle_clock_a: assert property (prog_enable_n && $past(prog_enable_n) |-> $stable(prog_clock_in))
		else $error("serial clock moved outside a frame");
	din_hold_a: assert property (!prog_enable_n && prog_clock_in && $past(prog_clock_in) |-> $stable(prog_data_in))
		else $error("data in changed while clock high");
	dout_hold_a: assert property (!prog_enable_n && prog_clock_in && $past(prog_clock_in) |-> $stable(prog_data_out))
		else $error("data out changed while clock high");
	frame_len_a: assert property (frame_end |-> nclk == 40)
		else $error("frame bit count wrong");
	break_len_a: assert property (break_end |-> lo_len >= BREAK_CYC)
		else $error("break too short");
	sym_period_a: assert property (sym_end |-> hi_prev + lo_len <= 18 * SUB)
		else $error("symbol period too long");
	sym_high_a: assert property ($fell(reset_pin_n) && hi_len < LONG |-> hi_len >= 2 * SUB)
		else $error("symbol high too short");
endmodule : rptl_link_asserts

/* dv/rptl_tb.sv */
// Testbench: programmer and device ends, plus a device fed by a faulty host
`timescale 1ns/1ps
module rptl_tb;
	localparam int SYM  = 160;
	localparam int EXIT = 1500;
	localparam int KT   = rptl_pkg::KEY_TRIAL_CYC;
	logic        clk_i, srst_i, enter_i, cmd_valid_i;
	logic [31:0] cmd_frame_i, last_cmd;
	logic [7:0]  key [rptl_pkg::KEY_BYTES];
	logic        ready_o, resp_valid_o, cmd_valid_o;
	logic [7:0]  resp_o, cmd_op_o, cmd_data_o, rsp;
	logic [15:0] cmd_addr_o, bit_time;
	logic        test_mode_o, unlocked_o, test_b, prog_mode;
	int          num_errors, cmp_count, n_cmd, busy_n;
	rptl_if u_link ();
	rptl_if u_link_b ();
	// Second device shares the serial wires; out of test mode it must ignore them
	assign u_link_b.prog_clock_in = u_link.prog_clock_in;
	assign u_link_b.prog_enable_n = u_link.prog_enable_n;
	assign u_link_b.prog_data_in  = u_link.prog_data_in;
	rptl_programmer #(.BREAK_CYC(2500), .SYM_CYC(SYM), .SCLK_DIV(8)) u_rptl_programmer (
		.clk_i(clk_i), .srst_i(srst_i), .link(u_link.programmer), .enter_i(enter_i),
		.cmd_valid_i(cmd_valid_i), .cmd_frame_i(cmd_frame_i), .ready_o(ready_o),
		.resp_valid_o(resp_valid_o), .resp_o(resp_o));
	rptl_device #(.BREAK_CYC(2000), .SYNC_CYC(1000), .EXIT_CYC(EXIT)) u_rptl_device (
		.clk_i(clk_i), .srst_i(srst_i), .link(u_link.device), .key_byte_i(key),
		.test_mode_o(test_mode_o), .program_mode_o(prog_mode), .unlocked_o(unlocked_o),
		.measured_bit_time_o(bit_time), .cmd_valid_o(cmd_valid_o), .cmd_op_o(cmd_op_o),
		.cmd_addr_o(cmd_addr_o), .cmd_data_o(cmd_data_o));
	// Second device: the bench plays a host that breaks the entry waveform
	rptl_device #(.BREAK_CYC(2000), .SYNC_CYC(1000), .EXIT_CYC(EXIT)) u_rptl_device_b (
		.clk_i(clk_i), .srst_i(srst_i), .link(u_link_b.device), .key_byte_i(key),
		.test_mode_o(test_b), .program_mode_o(), .unlocked_o(), .measured_bit_time_o(),
		.cmd_valid_o(), .cmd_op_o(), .cmd_addr_o(), .cmd_data_o());
	rptl_link_asserts #(.BREAK_CYC(2500), .SYM_CYC(SYM)) u_rptl_link_asserts (
		.clk_i(clk_i), .srst_i(srst_i), .reset_pin_n(u_link.reset_pin_n),
		.prog_clock_in(u_link.prog_clock_in), .prog_enable_n(u_link.prog_enable_n),
		.prog_data_in(u_link.prog_data_in), .prog_data_out(u_link.prog_data_out),
		.prog_busy(u_link.prog_busy));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(negedge clk_i) begin
		if (cmd_valid_o === 1'b1) begin
			n_cmd++;
			last_cmd = {cmd_op_o, cmd_addr_o, cmd_data_o};
		end
	end
	task automatic stop_test();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic timeout(input string what);
		num_errors++;
		$display("[FAIL] %s exp done got timeout", what);
		stop_test();
	endtask : timeout
	task automatic wait_hi(ref logic s, input int lim, input string what);
		for (int n = 0; s !== 1'b1; n++) begin
			@(negedge clk_i);
			if (n > lim) timeout(what);
		end
	endtask : wait_hi
	task automatic frame(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d);
		wait_hi(ready_o, 5000, "ready_o");
		cmd_valid_i = 1'b1;
		cmd_frame_i = {op, a, d};
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		busy_n = 0;
		// Erase length is not fixed, so the answer bound is generous
		for (int n = 0; resp_valid_o !== 1'b1; n++) begin
			@(negedge clk_i);
			busy_n += int'(u_link.prog_busy === 1'b1);
			if (n > 70000) timeout("resp_valid_o");
		end
		rsp = resp_o;
		for (int n = 0; u_link.prog_busy === 1'b1 && n < 3000; n++) begin
			@(negedge clk_i);
			busy_n++;
		end
	endtask : frame
	task automatic verify(input logic [7:0] x, input logic erased);
		logic [7:0] d;
		for (int i = 0; i < 8; i++) begin
			d = erased ? rptl_pkg::ERASED_BYTE : key[i];
			frame(rptl_pkg::OP_READ_VERIFY, 16'(rptl_pkg::KEY_ADDR_LO + i), d ^ ((i == 7) ? x : 8'h00));
		end
	endtask : verify
	task automatic session();
		enter_i = 1'b1;
		@(negedge clk_i);
		enter_i = 1'b0;
		wait_hi(test_mode_o, 20000, "test_mode_o");
		@(negedge clk_i);
		chk("program_mode", 1, 32'(prog_mode));
		chk("bit_time", 32'(SYM), 32'(bit_time));
		chk("unlocked", 0, 32'(unlocked_o));
		$display("Test entry done");
	endtask : session
	task automatic sym_b(input int hs, input int per);
		u_link_b.reset_pin_n = 1'b1;
		repeat (hs * SYM / 16) @(negedge clk_i);
		u_link_b.reset_pin_n = 1'b0;
		repeat (per - hs * SYM / 16) @(negedge clk_i);
	endtask : sym_b
	task automatic entry_b(input int brk, input logic [15:0] k, input int per, input logic exp);
		u_link_b.reset_pin_n = 1'b0;
		repeat (brk) @(negedge clk_i);
		repeat (3) sym_b(15, SYM);
		for (int i = 15; i >= 0; i--) sym_b(k[i] ? 12 : 4, per);
		sym_b(8, SYM);
		repeat (50) @(negedge clk_i);
		chk("test_b", 32'(exp), 32'(test_b));
		u_link_b.reset_pin_n = 1'b1;
		repeat (EXIT - 500) @(negedge clk_i);
		chk("test_b hold", 32'(exp), 32'(test_b));
		repeat (600) @(negedge clk_i);
		chk("test_b exit", 0, 32'(test_b));
		$display("Faulty host case done");
	endtask : entry_b
	initial begin
		srst_i = 1'b1;
		enter_i = 1'b0;
		cmd_valid_i = 1'b0;
		cmd_frame_i = 32'h0;
		for (int i = 0; i < 8; i++) key[i] = 8'(8'h11 * (i + 1));
		u_link_b.reset_pin_n = 1'b1;
		repeat (4) @(negedge clk_i);
		srst_i = 1'b0;
		@(negedge clk_i);
		chk("bit_time rst", 32'(rptl_pkg::BIT_TIME_RST), 32'(bit_time));
		entry_b(2500, 16'h5a96, SYM, 1'b1);
		entry_b(1500, 16'h5a96, SYM, 1'b0);
		entry_b(2500, 16'h5a97, SYM, 1'b0);
		entry_b(2500, 16'h5a96, 190, 1'b0);
		session();
		for (int op = 4; op <= 8; op++) begin
			frame(8'(op), 16'h0100, 8'h3c);
			chk("locked resp", 32'(rptl_pkg::RESP_REFUSED), 32'(rsp));
		end
		chk("locked cmds", 0, n_cmd);
		verify(8'h01, 1'b0);
		chk("unlocked bad key", 0, 32'(unlocked_o));
		verify(8'h00, 1'b0);
		chk("trial busy", 1, 32'(busy_n inside {[KT * 9 / 10 : KT * 11 / 10]}));
		chk("unlocked key", 1, 32'(unlocked_o));
		frame(rptl_pkg::OP_WRITE_INFO, 16'h0205, 8'h5b);
		chk("info write", 32'(rptl_pkg::RESP_OK), 32'(rsp));
		for (int op = 4; op <= 8; op++) begin
			frame(8'(op), 16'(16'h0200 + op), 8'(8'h40 + op));
			chk("resp", (8'(op) == rptl_pkg::OP_READ_INFO) ? 32'h5b : 32'(rptl_pkg::RESP_OK), 32'(rsp));
			chk("cmd", {8'(op), 16'(16'h0200 + op), 8'(8'h40 + op)}, last_cmd);
		end
		$display("Lock session done");
		srst_i = 1'b1;
		repeat (4) @(negedge clk_i);
		srst_i = 1'b0;
		@(negedge clk_i);
		chk("test after reset", 0, 32'(test_mode_o));
		chk("prog after reset", 0, 32'(prog_mode));
		session();
		frame(rptl_pkg::OP_ERASE_MAIN, 16'h0000, 8'h00);
		chk("erase resp", 32'(rptl_pkg::RESP_OK), 32'(rsp));
		verify(8'h00, 1'b1);
		chk("unlocked erased", 1, 32'(unlocked_o));
		$display("Erase session done");
		stop_test();
	end
endmodule : rptl_tb
